//--- rtl/stp_axis.sv
// One stepping-motor pulse axis with its command, data and status bytes.
module stp_axis #(
   parameter logic [7:0] CHIP_ID = 8'h5A // Arbitrary identification value.
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire stp_pkg::stp_bus_t bus,
   input wire logic origin_in,
   input wire logic start_trig_in,
   output logic [7:0] rdata,
   output logic pulse_a,
   output logic pulse_b,
   output logic irq
);
   import stp_pkg::*;

   stp_state_t q;
   stp_state_t d;
   logic [2:0] sel;
   logic ext_mon;
   logic hs;
   logic preset_mode;
   logic preset_hold;
   logic [23:0] cnt;
   logic [12:0] target;
   logic [22:0] prod;
   logic [ACC_W:0] sum;
   logic [10:0] period;
   logic near_end;
   logic rd_start;
   logic rd_clr;
   logic stop_now;
   logic ramp_set;
   logic stop_set;
   logic step;
   logic active;
   logic dir;
   logic [7:0] st0;
   logic [7:0] st1;
   logic [7:0] st2;
   logic [23:0] row;
   logic [23:0] wval;
   logic [4:0] bpos;

   assign rdata = q.rdata;
   assign pulse_a = q.pulse_a;
   assign pulse_b = q.pulse_b;
   assign irq = q.irq;

   always_comb begin
      d = q;
      sel = q.rsel_cmd[2:0];
      ext_mon = q.out_cmd[OM_EXT_BIT];
      preset_mode = (q.mode_cmd[2:0] == MODE_PRESET);
      preset_hold = q.rsel_cmd[RS_HOLD_BIT];
      cnt = q.regs[REG_PRESET];
      dir = q.mode_cmd[MD_DIR_BIT];
      hs = q.start_cmd[SS_RAMP_BIT] & q.start_cmd[SS_FH_BIT];
      stop_set = 1'b0;
      stop_now = 1'b0;
      step = 1'b0;
      rd_clr = 1'b0;
      wval = '0;
      bpos = '0;
      row = '0;

      // Input pins: two-stage synchroniser, then the width filter.
      d.sync1 = {start_trig_in, origin_in};
      d.sync2 = q.sync1;
      for (int i = 0; i < 2; i++) begin
         if (q.sync2[i] == q.filt[i]) begin
            d.fcnt[i] = '0;
         end else if (q.out_cmd[OM_SENS_BIT] || q.fcnt[i] == 7'(FILTER_CYC - 1)) begin
            d.filt[i] = q.sync2[i];
            d.fcnt[i] = '0;
         end else begin
            d.fcnt[i] = q.fcnt[i] + 7'h01;
         end
      end
      d.trig_q = q.filt[IN_TRIG];

      // Speed target for the current command.
      target = q.start_cmd[SS_FH_BIT] ? q.regs[REG_RUN_SPEED][12:0]
         : q.regs[REG_START_SPEED][12:0];
      if (hs && preset_mode && cnt < q.regs[REG_RAMP_DOWN]) begin
         target = q.regs[REG_START_SPEED][12:0];
      end
      if (q.decel) begin
         target = q.regs[REG_START_SPEED][12:0];
      end

      // Ramp timer; the S-curve slows the steps near the start speed and near the target speed.
      period = q.regs[REG_ACCEL][10:0];
      near_end = (q.cur_speed - q.regs[REG_START_SPEED][12:0] < SCURVE_BAND)
         || (target - q.cur_speed < SCURVE_BAND) || (q.cur_speed - target < SCURVE_BAND);
      if (q.mode_cmd[MD_PROF_BIT] && near_end) begin
         period = {q.regs[REG_ACCEL][9:0], 1'b0};
      end

      // Pulse rate from an accumulator fed by speed times multiplier.
      prod = q.cur_speed * q.regs[REG_MULT][9:0];
      sum = {1'b0, q.acc} + (ACC_W + 1)'(prod);

      unique case (q.st)
         ST_IDLE: begin
            d.acc = '0;
            d.acc_tmr = '0;
         end
         ST_WAIT: begin
            if (q.filt[IN_TRIG] && !q.trig_q) begin
               d.st = ST_RUN;
            end
         end
         ST_RUN: begin
            d.acc = sum[ACC_W-1:0];
            step = sum[ACC_W];
            if (q.out_cmd[OM_NOACC_BIT]) begin
               d.cur_speed = target;
               d.acc_tmr = '0;
            end else if (q.cur_speed != target) begin
               if (q.acc_tmr >= period) begin
                  d.acc_tmr = '0;
                  d.cur_speed = (q.cur_speed < target) ? q.cur_speed + 13'h0001
                     : q.cur_speed - 13'h0001;
               end else begin
                  d.acc_tmr = q.acc_tmr + 11'h001;
               end
            end
            if (step && !preset_hold && cnt != 24'h00_0000) begin
               d.regs[REG_PRESET] = cnt - 24'h00_0001;
            end
            // Manual mode has no stop source here besides commands.
            if (q.mode_cmd[2:0] == MODE_ORIGIN && q.filt[IN_ORIGIN]) begin
               stop_now = 1'b1;
            end
            if (preset_mode && cnt == 24'h00_0000) begin
               stop_now = 1'b1;
            end
            if (q.decel && q.cur_speed <= q.regs[REG_START_SPEED][12:0]) begin
               stop_now = 1'b1;
            end
            if (stop_now) begin
               d.st = ST_HALT;
               d.decel = 1'b0;
               d.start_cmd[SS_START_BIT] = 1'b0;
               stop_set = q.start_cmd[SS_INT_BIT];
            end
         end
         ST_HALT: begin
            d.acc = '0;
         end
      endcase

      // Step pulse stretcher and output encoding.
      if (step) begin
         d.hi_cnt = 4'(STEP_HIGH_CYC);
      end else if (q.hi_cnt != 4'h0) begin
         d.hi_cnt = q.hi_cnt - 4'h1;
      end
      active = (d.hi_cnt != 4'h0);
      if (q.regs[REG_OTYPE][0]) begin
         d.pulse_a = active;
         d.pulse_b = dir;
      end else begin
         d.pulse_a = active & ~dir;
         d.pulse_b = active & dir;
      end

      // Command byte writes.
      if (bus.wr && bus.addr == ADDR_CMD) begin
         unique case (stp_grp_t'(bus.wdata[7:6]))
            GRP_START: begin
               if (bus.wdata[SS_START_BIT]) begin
                  if (bus.wdata[3:2] == SS_DSTOP_CODE) begin
                     if (q.st == ST_RUN) begin
                        d.decel = 1'b1;
                        d.start_cmd[SS_INT_BIT] = bus.wdata[SS_INT_BIT];
                     end else if (q.st == ST_WAIT) begin
                        d.st = ST_HALT;
                        d.start_cmd[SS_START_BIT] = 1'b0;
                        stop_set = bus.wdata[SS_INT_BIT];
                     end
                  end else if (q.st == ST_IDLE) begin
                     // A start is only taken after a reset.
                     d.start_cmd = bus.wdata;
                     d.cur_speed = q.regs[REG_START_SPEED][12:0];
                     d.st = bus.wdata[SS_STBY_BIT] ? ST_WAIT : ST_RUN;
                  end else if (q.st == ST_RUN && !q.decel) begin
                     d.start_cmd = bus.wdata;
                  end
               end else if (bus.wdata[SS_RESET_BIT]) begin
                  d.st = ST_IDLE;
                  d.decel = 1'b0;
                  d.start_cmd[SS_START_BIT] = 1'b0;
                  stop_set = 1'b1;
               end
            end
            GRP_MODE: d.mode_cmd = bus.wdata;
            GRP_RSEL: d.rsel_cmd = bus.wdata;
            GRP_OUT: d.out_cmd = bus.wdata;
         endcase
      end

      // Data byte writes go into the selected register.
      if (bus.wr && bus.addr != ADDR_CMD) begin
         bpos = 5'(({3'h0, bus.addr} - 5'h01) << 3);
         wval = q.regs[sel];
         wval[bpos +: 8] = bus.wdata;
         d.regs[sel] = wval & REG_MASK[sel];
      end

      // Status bytes.
      st0 = {q.irq, q.st == ST_HALT, dir, q.filt[IN_ORIGIN], q.st == ST_WAIT,
         q.ramp_flag, q.stop_flag, q.st == ST_RUN};
      st1 = {q.st == ST_RUN, q.decel, hs, q.filt[IN_ORIGIN], q.filt[IN_TRIG],
         q.st == ST_WAIT, q.stop_flag, q.ramp_flag};
      st2 = {1'b0, q.st, q.mode_cmd[2:0], dir, q.out_cmd[OM_NOACC_BIT]};

      // Read row selected by monitor mode and register select.
      if (sel == REG_PRESET) begin
         row = q.regs[REG_PRESET];
      end else if (!ext_mon) begin
         row = {8'h00, 8'h00, st1};
      end else begin
         unique case (sel)
            REG_START_SPEED: row = {q.start_cmd, q.regs[sel][15:0]};
            REG_RUN_SPEED: row = {q.mode_cmd, q.regs[sel][15:0]};
            REG_ACCEL: row = {q.rsel_cmd, q.regs[sel][15:0]};
            REG_MULT: row = {q.out_cmd, q.regs[sel][15:0]};
            REG_RAMP_DOWN: row = {q.regs[REG_OTYPE][7:0], q.regs[sel][15:0]};
            REG_IDLE: row = {3'h0, q.cur_speed, q.regs[sel][7:0]};
            REG_OTYPE: row = {CHIP_ID, st2, st1};
            default: row = '0;
         endcase
      end

      // Reads latch once at the start and hold while rd stays high.
      d.rd_q = bus.rd;
      rd_start = bus.rd && !q.rd_q;
      if (rd_start) begin
         unique case (bus.addr)
            ADDR_CMD: d.rdata = st0;
            ADDR_DLO: d.rdata = row[7:0];
            ADDR_DMID: d.rdata = row[15:8];
            ADDR_DHI: d.rdata = row[23:16];
         endcase
         rd_clr = (bus.addr == ADDR_CMD);
      end

      // Interrupt sources; a new event beats a clear in the same cycle.
      ramp_set = preset_mode && q.st == ST_RUN && cnt < q.regs[REG_RAMP_DOWN];
      d.ramp_flag = d.rsel_cmd[RS_RDI_BIT] && (ramp_set || (q.ramp_flag && !rd_clr));
      d.stop_flag = stop_set || (q.stop_flag && !rd_clr);
      d.irq = q.out_cmd[OM_IEN_BIT] && (d.ramp_flag || d.stop_flag);
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         q <= '0;
      end else if (clk_en) begin
         q <= d;
      end
   end
endmodule

//--- rtl/stp_pkg.sv
// Constants, types and state layout of the stepper pulse axis controller.
package stp_pkg;
   localparam logic [1:0] ADDR_CMD = 2'h0;
   localparam logic [1:0] ADDR_DLO = 2'h1;
   localparam logic [1:0] ADDR_DMID = 2'h2;
   localparam logic [1:0] ADDR_DHI = 2'h3;

   typedef enum logic [1:0] {
      GRP_START = 2'b00,
      GRP_MODE = 2'b01,
      GRP_RSEL = 2'b10,
      GRP_OUT = 2'b11
   } stp_grp_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_WAIT = 2'b01,
      ST_RUN = 2'b10,
      ST_HALT = 2'b11
   } stp_st_t;

   // Start-stop command fields.
   localparam int SS_INT_BIT = 5;
   localparam int SS_START_BIT = 4;
   localparam int SS_RESET_BIT = 3;
   localparam int SS_RAMP_BIT = 2;
   localparam int SS_STBY_BIT = 1;
   localparam int SS_FH_BIT = 0;
   localparam logic [1:0] SS_DSTOP_CODE = 2'h3;
   // Operation mode command fields.
   localparam int MD_PROF_BIT = 5;
   localparam int MD_DIR_BIT = 3;
   localparam logic [2:0] MODE_ORIGIN = 3'h2;
   localparam logic [2:0] MODE_PRESET = 3'h4;
   // Register select command fields.
   localparam int RS_RDI_BIT = 4;
   localparam int RS_HOLD_BIT = 3;
   // Output mode command fields.
   localparam int OM_NOACC_BIT = 3;
   localparam int OM_SENS_BIT = 2;
   localparam int OM_EXT_BIT = 1;
   localparam int OM_IEN_BIT = 0;

   localparam logic [2:0] REG_PRESET = 3'h0;
   localparam logic [2:0] REG_START_SPEED = 3'h1;
   localparam logic [2:0] REG_RUN_SPEED = 3'h2;
   localparam logic [2:0] REG_ACCEL = 3'h3;
   localparam logic [2:0] REG_MULT = 3'h4;
   localparam logic [2:0] REG_RAMP_DOWN = 3'h5;
   localparam logic [2:0] REG_IDLE = 3'h6;
   localparam logic [2:0] REG_OTYPE = 3'h7;
   localparam logic [7:0][23:0] REG_MASK = {24'h00_0001, 24'h00_0007, 24'h00_FFFF,
      24'h00_03FF, 24'h00_03FF, 24'h00_1FFF, 24'h00_1FFF, 24'hFF_FFFF};

   localparam int CLK_NS = 10;
   localparam int FILTER_NS = 800;
   localparam int FILTER_CYC = (FILTER_NS + CLK_NS - 1) / CLK_NS;
   localparam int STEP_HIGH_NS = 100;
   localparam int STEP_HIGH_CYC = (STEP_HIGH_NS + CLK_NS - 1) / CLK_NS;
   localparam int ACC_W = 28;
   localparam logic [12:0] SCURVE_BAND = 13'h0010;
   localparam int IN_ORIGIN = 0;
   localparam int IN_TRIG = 1;

   typedef struct packed {
      logic [1:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } stp_bus_t;

   typedef struct packed {
      stp_st_t st;
      logic [7:0][23:0] regs;
      logic [7:0] start_cmd;
      logic [7:0] mode_cmd;
      logic [7:0] rsel_cmd;
      logic [7:0] out_cmd;
      logic decel;
      logic [12:0] cur_speed;
      logic [ACC_W-1:0] acc;
      logic [10:0] acc_tmr;
      logic [3:0] hi_cnt;
      logic pulse_a;
      logic pulse_b;
      logic irq;
      logic stop_flag;
      logic ramp_flag;
      logic rd_q;
      logic [7:0] rdata;
      logic [1:0] sync1;
      logic [1:0] sync2;
      logic [1:0] filt;
      logic [1:0][6:0] fcnt;
      logic trig_q;
   } stp_state_t;
endpackage

//--- dv/stp_axis_sva.sv
// Port checker for the stepper pulse axis.
module stp_axis_sva
   import stp_pkg::*;
#(
   parameter logic [7:0] CHIP_ID = 8'h5A
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire stp_pkg::stp_bus_t bus,
   input wire logic origin_in,
   input wire logic start_trig_in,
   input wire logic [7:0] rdata,
   input wire logic pulse_a,
   input wire logic pulse_b,
   input wire logic irq
);
   logic [7:0] oc;
   logic [2:0] sel;
   logic rd_q;
   logic cw;
   logic take;
   logic rst;
   assign cw = clk_en && bus.wr && bus.addr == ADDR_CMD;
   assign take = clk_en && bus.rd && !rd_q;
   assign rst = cw && bus.wdata[7:6] == GRP_START && bus.wdata[4:3] == 2'h1;
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         oc <= 8'h00;
         sel <= 3'h0;
         rd_q <= 1'b0;
      end else if (clk_en) begin
         rd_q <= bus.rd;
         if (cw && bus.wdata[7:6] == GRP_OUT) begin
            oc <= bus.wdata;
         end
         if (cw && bus.wdata[7:6] == GRP_RSEL) begin
            sel <= bus.wdata[2:0];
         end
      end
   end
   default clocking @(posedge mclk);
   endclocking
   default disable iff (!reset_n);
   reset_clear_a: assert property (
      reset_n && !$past(reset_n) |-> rdata == 8'h00 && !irq && !pulse_a && !pulse_b)
      else $error("outputs not clear after reset");
   step_width_a: assert property (
      $rose(pulse_a) |-> pulse_a[*8] ##1 pulse_a[*2] ##1 !pulse_a)
      else $error("step pulse width wrong");
   read_hold_a: assert property (!take |=> $stable(rdata))
      else $error("read data moved outside a read");
   reset_irq_a: assert property (
      rst && bus.wdata[SS_INT_BIT] && oc[OM_IEN_BIT] |-> ##[1:3] irq)
      else $error("no interrupt after reset command");
   reset_quiet_a: assert property (rst |-> ##2 (!$rose(pulse_a))[*8])
      else $error("pulse after reset command");
   irq_gate_a: assert property (
      !oc[OM_IEN_BIT] && !$past(oc[OM_IEN_BIT]) && !$past(oc[OM_IEN_BIT], 2) |-> !irq)
      else $error("interrupt while disabled");
   chip_code_a: assert property (
      take && bus.addr == ADDR_DHI && sel == REG_OTYPE && oc[OM_EXT_BIT] |=> rdata == CHIP_ID)
      else $error("identity byte wrong");
   write_only_a: assert property (
      take && bus.addr == ADDR_DMID && sel != REG_PRESET && !oc[OM_EXT_BIT] |=> rdata == 8'h00)
      else $error("standard monitor middle byte not zero");
   cover property ($rose(pulse_a));
   cover property ($rose(irq));
   cover property (take && bus.addr == ADDR_DHI && sel == REG_OTYPE);
endmodule

bind stp_axis stp_axis_sva #(.CHIP_ID(CHIP_ID)) u_sva (.mclk(mclk), .reset_n(reset_n),
   .clk_en(clk_en), .bus(bus), .origin_in(origin_in), .start_trig_in(start_trig_in),
   .rdata(rdata), .pulse_a(pulse_a), .pulse_b(pulse_b), .irq(irq));

//--- dv/stp_motor_model.sv
// Motor driver model: counts steps, tracks position and closes an origin switch.
module stp_motor_model (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic pulse_a,
   input wire logic pulse_b,
   input wire logic dir_type,
   input wire logic signed [31:0] home,
   output logic origin_in,
   output int steps,
   output int pos
);
   logic a_q;
   logic b_q;
   assign origin_in = pos >= home;
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         a_q <= 1'b0;
         b_q <= 1'b0;
         steps <= 0;
         pos <= 0;
      end else begin
         a_q <= pulse_a;
         b_q <= pulse_b;
         if (pulse_a && !a_q) begin
            steps <= steps + 1;
            pos <= (dir_type && pulse_b) ? pos - 1 : pos + 1;
         end else if (!dir_type && pulse_b && !b_q) begin
            steps <= steps + 1;
            pos <= pos - 1;
         end
      end
   end
endmodule

//--- dv/test_stepper_pulse_axis_controller.sv
// Self-checking bench for the stepper pulse axis with a motor model.
module test_stepper_pulse_axis_controller
   import stp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [7:0] ID = 8'h3C; // Arbitrary identification value.
   logic mclk = 1'b0;
   logic reset_n = 1'b0;
   logic clk_en = 1'b1;
   logic trig = 1'b0;
   logic dtype = 1'b1;
   logic signed [31:0] home = 32'sh7FFF_FFFF;
   stp_bus_t bus = '0;
   logic origin_in;
   logic pulse_a;
   logic pulse_b;
   logic irq;
   logic [7:0] rdata;
   logic [7:0] q;
   int steps;
   int pos;
   int s0;
   int bad_count = 0;
   int num_checks = 0;
   stp_axis #(.CHIP_ID(ID)) dut (.mclk(mclk), .reset_n(reset_n), .clk_en(clk_en), .bus(bus),
      .origin_in(origin_in), .start_trig_in(trig), .rdata(rdata), .pulse_a(pulse_a),
      .pulse_b(pulse_b), .irq(irq));
   stp_motor_model motor (.mclk(mclk), .reset_n(reset_n), .pulse_a(pulse_a), .pulse_b(pulse_b),
      .dir_type(dtype), .home(home), .origin_in(origin_in), .steps(steps), .pos(pos));
   initial forever #5 mclk = ~mclk;
   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      num_checks++;
      if (s !== e) begin
         bad_count++;
         $display("Error at %0t: saw %h expected %h", $time, s, e);
      end
   endtask
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge mclk) bus <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
      @(posedge mclk) bus.wr <= 1'b0;
   endtask
   task automatic rd(input logic [1:0] a);
      @(posedge mclk) begin
         bus.addr <= a;
         bus.rd <= 1'b1;
      end
      @(posedge mclk) bus.rd <= 1'b0;
      #1 q = rdata;
   endtask
   task automatic setreg(input logic [2:0] i, input logic [23:0] v);
      wr(ADDR_CMD, {GRP_RSEL, 3'h0, i});
      wr(ADDR_DLO, v[7:0]);
      wr(ADDR_DMID, v[15:8]);
      wr(ADDR_DHI, v[23:16]);
   endtask
   task automatic wait_halt();
      q = 8'h00;
      for (int i = 0; i < 300 && q[6] !== 1'b1; i++) begin
         repeat (20) @(posedge mclk);
         rd(ADDR_CMD);
      end
      chk({7'h0, q[6]}, 8'h01);
   endtask
   task automatic wait_steps(input int n);
      for (int i = 0; i < 20000 && steps < n; i++) @(posedge mclk);
      // Let the model's step count settle past the edge before it is judged.
      #1;
   endtask
   task automatic wait_irq();
      for (int i = 0; i < 20000 && irq !== 1'b1; i++) @(posedge mclk);
      #1;
   endtask
   task automatic trig_pulse();
      @(posedge mclk) trig <= 1'b1;
      repeat (40) @(posedge mclk);
      trig <= 1'b0;
      repeat (300) @(posedge mclk);
   endtask
   task automatic t_regs();
      setreg(REG_START_SPEED, 24'hFA0);
      setreg(REG_RUN_SPEED, 24'hFB4);
      setreg(REG_MULT, 24'h3E8);
      setreg(REG_ACCEL, 24'h2);
      setreg(REG_OTYPE, 24'h1);
      wr(ADDR_CMD, 8'hC2);
      setreg(REG_PRESET, 24'hAB_CDEF);
      rd(ADDR_DLO); chk(q, 8'hEF);
      // A write while the clock enable is low must leave the register alone.
      @(posedge mclk) clk_en <= 1'b0;
      wr(ADDR_DLO, 8'h11);
      clk_en <= 1'b1;
      rd(ADDR_DLO); chk(q, 8'hEF);
      rd(ADDR_DHI); chk(q, 8'hAB);
      setreg(REG_RAMP_DOWN, 24'h01_2345);
      rd(ADDR_DMID); chk(q, 8'h23);
      rd(ADDR_DHI); chk(q, 8'h01);
      wr(ADDR_CMD, 8'h87);
      rd(ADDR_DHI); chk(q, ID);
      wr(ADDR_CMD, 8'hC0);
      rd(ADDR_DMID); chk(q, 8'h00);
      $display("register test done");
   endtask
   task automatic t_motion(input logic neg);
      dtype = !neg;
      setreg(REG_OTYPE, {23'h0, !neg});
      wr(ADDR_CMD, neg ? 8'h49 : 8'h41);
      s0 = pos;
      wr(ADDR_CMD, 8'h15);
      repeat (700) @(posedge mclk);
      chk(8'((neg ? s0 - pos : pos - s0) inside {[9:11]}), 8'h01);
      wr(ADDR_CMD, 8'h1C);
      wait_halt();
      s0 = steps;
      repeat (300) @(posedge mclk);
      chk(8'(steps - s0), 8'h00);
      wr(ADDR_CMD, 8'h08);
      $display("motion test done");
   endtask
   task automatic t_preset();
      // The last reset command left the stop flag set; read it away first.
      rd(ADDR_CMD);
      wr(ADDR_CMD, 8'hC1);
      setreg(REG_PRESET, 24'h5);
      setreg(REG_RAMP_DOWN, 24'h3);
      wr(ADDR_CMD, 8'h90);
      wr(ADDR_CMD, 8'h44);
      s0 = steps;
      wr(ADDR_CMD, 8'h30);
      wait_irq();
      chk(8'(steps - s0), 8'h03);
      wr(ADDR_CMD, 8'h80);
      repeat (3) @(posedge mclk);
      chk({7'h0, irq}, 8'h00);
      wait_irq();
      chk(8'(steps - s0), 8'h05);
      rd(ADDR_CMD); chk(q & 8'hC7, 8'hC2);
      repeat (2) @(posedge mclk);
      chk({7'h0, irq}, 8'h00);
      wr(ADDR_CMD, 8'h08);
      rd(ADDR_CMD);
      setreg(REG_PRESET, 24'h2);
      s0 = steps;
      wr(ADDR_CMD, 8'h10);
      wait_steps(s0 + 2);
      repeat (20) @(posedge mclk);
      chk({7'h0, irq}, 8'h00);
      $display("preset test done");
   endtask
   task automatic t_hold();
      wr(ADDR_CMD, 8'h08);
      rd(ADDR_CMD);
      setreg(REG_PRESET, 24'h5);
      wr(ADDR_CMD, 8'h88);
      s0 = steps;
      wr(ADDR_CMD, 8'h10);
      wait_steps(s0 + 8);
      rd(ADDR_DLO); chk(q, 8'h05);
      @(negedge pulse_a);
      wr(ADDR_CMD, 8'h28);
      repeat (3) @(posedge mclk);
      chk({7'h0, irq}, 8'h01);
      s0 = steps;
      repeat (300) @(posedge mclk);
      chk(8'(steps - s0), 8'h00);
      rd(ADDR_DLO); chk(q, 8'h05);
      rd(ADDR_CMD);
      $display("hold test done");
   endtask
   task automatic t_origin();
      home = pos + 3;
      wr(ADDR_CMD, 8'hC5);
      wr(ADDR_CMD, 8'h42);
      wr(ADDR_CMD, 8'h10);
      wait_halt();
      chk(8'((pos - home) inside {[0:1]}), 8'h01);
      home = 32'sh7FFF_FFFF;
      wr(ADDR_CMD, 8'h08);
      $display("origin test done");
   endtask
   task automatic t_standby();
      wr(ADDR_CMD, 8'hC1);
      wr(ADDR_CMD, 8'h41);
      s0 = steps;
      wr(ADDR_CMD, 8'h12);
      trig_pulse();
      chk(8'(steps - s0), 8'h00);
      wr(ADDR_CMD, 8'hC5);
      trig_pulse();
      chk(8'(steps > s0), 8'h01);
      wr(ADDR_CMD, 8'h1C);
      wait_halt();
      wr(ADDR_CMD, 8'h08);
      $display("standby test done");
   endtask
   task automatic t_accel(input logic [7:0] oc, input logic [7:0] lo);
      setreg(REG_ACCEL, 24'h3FF);
      wr(ADDR_CMD, oc);
      wr(ADDR_CMD, 8'h15);
      wr(ADDR_CMD, 8'h86);
      rd(ADDR_DMID); chk(q, lo);
      wr(ADDR_CMD, 8'h1C);
      wait_halt();
      wr(ADDR_CMD, 8'h08);
      $display("acceleration test done");
   endtask
   task automatic conclude();
      $display("Checks %0d, mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   initial begin
      repeat (50000) @(posedge mclk);
      bad_count++;
      $display("Error at %0t: watchdog expired", $time);
      conclude();
   end
   initial begin
      repeat (16) @(posedge mclk);
      reset_n <= 1'b1;
      t_regs();
      t_motion(1'b0);
      t_motion(1'b1);
      t_preset();
      t_hold();
      t_origin();
      t_standby();
      t_accel(8'hCA, 8'hB4);
      t_accel(8'hC2, 8'hA0);
      conclude();
   end
endmodule
